/* src/amr_pkg.sv */
`default_nettype none
package amr_pkg;
  localparam int ADDR_W     = 32;
  localparam int DATA_W     = 32;
  localparam int BEATS_W    = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int SLV_IDX_W  = 6;
  localparam int SLV_WORDS  = 64;
  localparam int LANES      = 4;

  localparam logic [1:0] TRANS_IDLE   = 2'h0;
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  localparam logic [1:0] TRANS_SEQ    = 2'h3;
  localparam logic [2:0] BURST_SINGLE = 3'h0;
  localparam logic [2:0] BURST_INCR   = 3'h1;
  localparam logic [1:0] SIZE_BYTE    = 2'h0;
  localparam logic [1:0] SIZE_HALF    = 2'h1;
  localparam logic [1:0] SIZE_WORD    = 2'h2;
  localparam logic [2:0] RESP_OKAY    = 3'h0;
  localparam logic [2:0] RESP_ERROR   = 3'h1;

  localparam logic [3:0] STRB_ALL     = 4'hf;
  localparam logic [3:0] STRB_NONE    = 4'h0;
  localparam logic [3:0] WORD_BYTES   = 4'h4;
  localparam logic [3:0] REM_THREE    = 4'h3;
  localparam logic [1:0] ALIGN_OFS    = 2'h0;
  localparam logic [31:0] WORD_STEP   = 32'h4;
  localparam logic [29:0] WORD_INC    = 30'h1;
  localparam logic [31:0] ZERO_WORD   = 32'h0;
  localparam logic [7:0] BEATS_ONE    = 8'h01;
  localparam logic [7:0] BEATS_ZERO   = 8'h00;
  localparam logic [1:0] WAIT_ZERO    = 2'h0;
  localparam logic [1:0] WAIT_ONE     = 2'h1;

  typedef enum logic [1:0] {
    OP_IDLE   = 2'b00,
    OP_FIRST  = 2'b01,
    OP_SECOND = 2'b11
  } amr_op_type;

  typedef enum logic [1:0] {
    SL_READY = 2'b00,
    SL_WAIT  = 2'b01,
    SL_ERR1  = 2'b11,
    SL_ERR2  = 2'b10
  } amr_sl_type;
endpackage
`default_nettype wire

/* src/amr_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface amr_bus_if;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hburst;
  logic [1:0]  hsize;
  logic [3:0]  hbstrb;
  logic        hwrite;
  logic        hunalign;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic [2:0]  hresp;

  modport master (
    output haddr, htrans, hburst, hsize, hbstrb, hwrite, hunalign, hwdata,
    input  hrdata, hready, hresp
  );
  modport slave (
    input  haddr, htrans, hburst, hsize, hbstrb, hwrite, hunalign, hwdata,
    output hrdata, hready, hresp
  );
endinterface
`default_nettype wire

/* src/amr_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module amr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wptr_reg;
  logic [PW:0]      wptr_next;
  logic [PW:0]      rptr_reg;
  logic [PW:0]      rptr_next;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty without a counter.
  assign out_valid_o = (wptr_reg != rptr_reg);
  assign in_ready_o  = (wptr_reg[PW-1:0] != rptr_reg[PW-1:0]) || (wptr_reg[PW] == rptr_reg[PW]);
  assign out_data_o  = mem[rptr_reg[PW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
    rptr_next = pop ? rptr_reg + 1'b1 : rptr_reg;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wptr_reg[PW-1:0]] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

/* src/amr_master.sv */
// Contract
// - hwrite low for reads, high for writes
// - first misaligned portion sizes whole item
// - first misaligned portion: unalign high, NONSEQ
// - strobes mark lanes; slaves select by strobes
// - second portion NONSEQ, next word, pipelined
// - second portion size: remaining bytes, rounded up
// - second portion unalign only for three bytes
// - following aligned transfers NONSEQ, unalign low
// - wait states hold transfer until ready
// - one outstanding transfer; request held until taken
// - bursts always use INCR encoding
// - bursts: unalign low, word size, all strobes
// - burst word aligned, increments by word
// - burst length is arbitrary, even one
// - bursts end anytime, next transfer without idle
// - untaken request may be replaced by another
// - only reads retracted; writes held unchanged
// - later burst beats retractable, replacement taken next
// - write data driven cycle after address taken
// - error two cycles; pending request dropped second
`timescale 1ns/1ps
`default_nettype none
module amr_master (
  // Clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     rst_i,
  // Bus
  amr_bus_if.master                     bus,
  // Command
  input  wire logic                     req_valid_i,
  output logic                          req_ready_o,
  input  wire logic [amr_pkg::ADDR_W-1:0] req_addr_i,
  input  wire logic                     req_write_i,
  input  wire logic [1:0]               req_size_i,
  input  wire logic                     req_burst_i,
  input  wire logic [amr_pkg::BEATS_W-1:0] req_beats_i,
  input  wire logic                     req_retract_i,
  // Write data
  input  wire logic                     wr_valid_i,
  output logic                          wr_ready_o,
  input  wire logic [amr_pkg::DATA_W-1:0] wr_data_i,
  // Completions
  output logic                          resp_valid_o,
  output logic                          resp_write_o,
  output logic                          resp_error_o,
  output logic [amr_pkg::DATA_W-1:0]    rd_data_o
);
  import amr_pkg::*;

  amr_op_type       op_state_reg;
  amr_op_type       op_state_next;
  logic [31:0]      op_addr_reg;
  logic [31:0]      op_addr_next;
  logic             op_write_reg;
  logic             op_write_next;
  logic [1:0]       op_size_reg;
  logic [1:0]       op_size_next;
  logic             op_burst_reg;
  logic             op_burst_next;
  logic [7:0]       op_beats_reg;
  logic [7:0]       op_beats_next;
  logic             op_seq_reg;
  logic             op_seq_next;
  logic             dp_valid_reg;
  logic             dp_valid_next;
  logic             dp_write_reg;
  logic             dp_write_next;
  logic             err_pend_reg;
  logic             err_pend_next;
  logic [31:0]      wdata_reg;
  logic [31:0]      wdata_next;
  logic             resp_valid_reg;
  logic             resp_valid_next;
  logic             resp_write_reg;
  logic             resp_write_next;
  logic             resp_error_reg;
  logic             resp_error_next;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;

  logic             fifo_valid;
  logic             fifo_pop;
  logic [31:0]      fifo_data;
  logic [2:0]       nbytes;
  logic [3:0]       span;
  logic [3:0]       rem;
  logic [7:0]       lane_mask;
  logic [7:0]       lane_shift;
  logic             misal;
  logic             presenting;
  logic             taken;
  logic             last_portion;
  logic             retract_ok;
  logic             accept;
  logic [1:0]       trans_c;
  logic             err_first;

  // Write data waits here so the source can run ahead of the bus.
  amr_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .in_valid_i  (wr_valid_i),
    .in_ready_o  (wr_ready_o),
    .in_data_i   (wr_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  always_comb begin
    case (op_size_reg)
      SIZE_BYTE: nbytes = 3'h1;
      SIZE_HALF: nbytes = 3'h2;
      default:   nbytes = 3'h4;
    endcase
  end

  assign span       = {2'b00, op_addr_reg[1:0]} + {1'b0, nbytes};
  assign rem        = span - WORD_BYTES;
  assign misal      = !op_burst_reg && (span > WORD_BYTES);
  assign lane_mask  = (8'h01 << nbytes) - 8'h01;
  assign lane_shift = lane_mask << op_addr_reg[1:0];

  // A write is only presented once its data word is queued, so it never has to change after it appears.
  assign presenting = (op_state_reg != OP_IDLE) && !err_pend_reg && (!op_write_reg || fifo_valid);
  assign taken      = presenting && bus.hready;
  assign fifo_pop   = taken && op_write_reg;

  always_comb begin
    bus.haddr    = op_addr_reg;
    bus.hsize    = op_size_reg;
    bus.hbstrb   = lane_shift[3:0];
    bus.hunalign = misal;
    bus.hburst   = BURST_SINGLE;
    bus.hwrite   = op_write_reg;
    trans_c      = TRANS_NONSEQ;
    if (op_burst_reg) begin
      bus.haddr    = {op_addr_reg[31:2], ALIGN_OFS};
      bus.hsize    = SIZE_WORD;
      bus.hbstrb   = STRB_ALL;
      bus.hunalign = 1'b0;
      bus.hburst   = BURST_INCR;
      trans_c      = op_seq_reg ? TRANS_SEQ : TRANS_NONSEQ;
    end else if (op_state_reg == OP_SECOND) begin
      bus.haddr    = {op_addr_reg[31:2] + WORD_INC, ALIGN_OFS};
      bus.hbstrb   = 4'((4'h1 << rem[1:0]) - 4'h1);
      bus.hunalign = (rem == REM_THREE);
      case (rem[1:0])
        2'h1:    bus.hsize = SIZE_BYTE;
        2'h2:    bus.hsize = SIZE_HALF;
        default: bus.hsize = SIZE_WORD;
      endcase
    end
    bus.htrans = presenting ? trans_c : TRANS_IDLE;
    bus.hwdata = wdata_reg;
  end

  assign last_portion = op_burst_reg ? (op_beats_reg == BEATS_ONE) : ((op_state_reg == OP_SECOND) || !misal);
  // Replacement is only accepted while the old read cannot be taken this cycle.
  assign retract_ok   = req_valid_i && req_retract_i && !op_write_reg && !bus.hready &&
                        (op_state_reg == OP_FIRST) && !err_pend_reg;
  // Nothing is accepted in the first error cycle, since the second one would drop it unanswered.
  assign err_first    = dp_valid_reg && !bus.hready && (bus.hresp == RESP_ERROR);
  assign req_ready_o  = (((op_state_reg == OP_IDLE) && !err_pend_reg) || (taken && last_portion) || retract_ok) &&
                        !err_first;
  assign accept       = req_valid_i && req_ready_o;

  always_comb begin
    op_state_next = op_state_reg;
    op_addr_next  = op_addr_reg;
    op_write_next = op_write_reg;
    op_size_next  = op_size_reg;
    op_burst_next = op_burst_reg;
    op_beats_next = op_beats_reg;
    op_seq_next   = op_seq_reg;
    if (err_pend_reg) begin
      op_state_next = OP_IDLE;
    end else if (accept) begin
      op_state_next = OP_FIRST;
      op_addr_next  = req_burst_i ? {req_addr_i[31:2], ALIGN_OFS} : req_addr_i;
      op_write_next = req_write_i;
      op_size_next  = req_size_i;
      op_burst_next = req_burst_i;
      op_beats_next = (req_burst_i && (req_beats_i != BEATS_ZERO)) ? req_beats_i : BEATS_ONE;
      op_seq_next   = 1'b0;
    end else if (taken) begin
      if (op_burst_reg) begin
        op_state_next = OP_FIRST;
        op_addr_next  = op_addr_reg + WORD_STEP;
        op_beats_next = op_beats_reg - BEATS_ONE;
        op_seq_next   = 1'b1;
        if (last_portion) begin
          op_state_next = OP_IDLE;
        end
      end else if (misal && (op_state_reg == OP_FIRST)) begin
        op_state_next = OP_SECOND;
      end else begin
        op_state_next = OP_IDLE;
      end
    end
  end

  always_comb begin
    dp_valid_next   = taken || (dp_valid_reg && !bus.hready);
    dp_write_next   = taken ? op_write_reg : dp_write_reg;
    wdata_next      = fifo_pop ? fifo_data : wdata_reg;
    // The first error cycle is remembered so the pending request can be withdrawn in the second.
    err_pend_next   = err_first;
    resp_valid_next = dp_valid_reg && bus.hready;
    resp_write_next = dp_write_reg;
    resp_error_next = dp_valid_reg && bus.hready && (bus.hresp == RESP_ERROR);
    rdata_next      = (dp_valid_reg && bus.hready && !dp_write_reg) ? bus.hrdata : rdata_reg;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      op_state_reg   <= OP_IDLE;
      op_addr_reg    <= ZERO_WORD;
      op_write_reg   <= 1'b0;
      op_size_reg    <= SIZE_BYTE;
      op_burst_reg   <= 1'b0;
      op_beats_reg   <= BEATS_ONE;
      op_seq_reg     <= 1'b0;
      dp_valid_reg   <= 1'b0;
      dp_write_reg   <= 1'b0;
      err_pend_reg   <= 1'b0;
      wdata_reg      <= ZERO_WORD;
      resp_valid_reg <= 1'b0;
      resp_write_reg <= 1'b0;
      resp_error_reg <= 1'b0;
      rdata_reg      <= ZERO_WORD;
    end else begin
      op_state_reg   <= op_state_next;
      op_addr_reg    <= op_addr_next;
      op_write_reg   <= op_write_next;
      op_size_reg    <= op_size_next;
      op_burst_reg   <= op_burst_next;
      op_beats_reg   <= op_beats_next;
      op_seq_reg     <= op_seq_next;
      dp_valid_reg   <= dp_valid_next;
      dp_write_reg   <= dp_write_next;
      err_pend_reg   <= err_pend_next;
      wdata_reg      <= wdata_next;
      resp_valid_reg <= resp_valid_next;
      resp_write_reg <= resp_write_next;
      resp_error_reg <= resp_error_next;
      rdata_reg      <= rdata_next;
    end
  end

  assign resp_valid_o = resp_valid_reg;
  assign resp_write_o = resp_write_reg;
  assign resp_error_o = resp_error_reg;
  assign rd_data_o    = rdata_reg;
endmodule
`default_nettype wire

/* src/amr_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module amr_slave (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // Bus
  amr_bus_if.slave         bus,
  // Response control
  input  wire logic [1:0]  wait_cycles_i,
  input  wire logic        error_i,
  // Observation
  output logic             take_valid_o,
  output logic             take_write_o,
  output logic [31:0]      take_addr_o
);
  import amr_pkg::*;

  amr_sl_type       st_reg;
  amr_sl_type       st_next;
  logic [1:0]       cnt_reg;
  logic [1:0]       cnt_next;
  logic             dp_valid_reg;
  logic             dp_valid_next;
  logic             dp_write_reg;
  logic             dp_write_next;
  logic [SLV_IDX_W-1:0] dp_idx_reg;
  logic [SLV_IDX_W-1:0] dp_idx_next;
  logic [3:0]       dp_strb_reg;
  logic [3:0]       dp_strb_next;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;
  logic             tk_valid_reg;
  logic             tk_write_reg;
  logic [31:0]      tk_addr_reg;
  logic [31:0]      fwd;
  logic             take;
  logic             commit;

  assign bus.hready = (st_reg == SL_READY) || (st_reg == SL_ERR2);
  assign bus.hresp  = ((st_reg == SL_ERR1) || (st_reg == SL_ERR2)) ? RESP_ERROR : RESP_OKAY;
  assign bus.hrdata = rdata_reg;
  // Attributes are sampled only here, so retracted requests leave no trace.
  assign take       = bus.htrans[1] && bus.hready;
  assign commit     = dp_valid_reg && dp_write_reg && (st_reg == SL_READY);

  // Lanes come from the strobes, never from size and low address bits.
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    // Each lane owns its array, so no two processes write the same variable.
    logic [7:0] lane_mem [SLV_WORDS];
    assign fwd[8*i +: 8] = (commit && dp_strb_reg[i] && (dp_idx_reg == bus.haddr[SLV_IDX_W+1:2])) ?
                           bus.hwdata[8*i +: 8] : lane_mem[bus.haddr[SLV_IDX_W+1:2]];
    always_ff @(posedge clock_i) begin
      if (commit && dp_strb_reg[i]) begin
        lane_mem[dp_idx_reg] <= bus.hwdata[8*i +: 8];
      end
    end
  end

  always_comb begin
    st_next       = st_reg;
    cnt_next      = cnt_reg;
    dp_valid_next = take || (dp_valid_reg && !bus.hready);
    dp_write_next = take ? bus.hwrite : dp_write_reg;
    dp_idx_next   = take ? bus.haddr[SLV_IDX_W+1:2] : dp_idx_reg;
    dp_strb_next  = take ? (bus.hwrite ? bus.hbstrb : STRB_ALL) : dp_strb_reg;
    rdata_next    = (take && !bus.hwrite) ? fwd : rdata_reg;
    case (st_reg)
      SL_READY, SL_ERR2: begin
        st_next = SL_READY;
        if (take && error_i) begin
          st_next = SL_ERR1;
        end else if (take && (wait_cycles_i != WAIT_ZERO)) begin
          st_next  = SL_WAIT;
          cnt_next = wait_cycles_i;
        end
      end
      SL_WAIT: begin
        cnt_next = cnt_reg - WAIT_ONE;
        if (cnt_reg == WAIT_ONE) begin
          st_next = SL_READY;
        end
      end
      SL_ERR1: st_next = SL_ERR2;
      default: st_next = SL_READY;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg       <= SL_READY;
      cnt_reg      <= WAIT_ZERO;
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_idx_reg   <= '0;
      dp_strb_reg  <= STRB_NONE;
      rdata_reg    <= ZERO_WORD;
      tk_valid_reg <= 1'b0;
      tk_write_reg <= 1'b0;
      tk_addr_reg  <= ZERO_WORD;
    end else begin
      st_reg       <= st_next;
      cnt_reg      <= cnt_next;
      dp_valid_reg <= dp_valid_next;
      dp_write_reg <= dp_write_next;
      dp_idx_reg   <= dp_idx_next;
      dp_strb_reg  <= dp_strb_next;
      rdata_reg    <= rdata_next;
      tk_valid_reg <= take;
      tk_write_reg <= take ? bus.hwrite : tk_write_reg;
      tk_addr_reg  <= take ? bus.haddr : tk_addr_reg;
    end
  end

  assign take_valid_o = tk_valid_reg;
  assign take_write_o = tk_write_reg;
  assign take_addr_o  = tk_addr_reg;
endmodule
`default_nettype wire

/* testbench/amr_bus_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module amr_bus_properties
  import amr_pkg::*;
(
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        rst_i,
  // Watched bus signals
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic [2:0]  hburst,
  input wire logic [1:0]  hsize,
  input wire logic [3:0]  hbstrb,
  input wire logic        hwrite,
  input wire logic        hunalign,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [2:0]  hresp
);
  logic       take;
  logic       first_part;
  logic [3:0] rem;

  // A misaligned first portion is the only request with the flag high on an unaligned address.
  assign take       = htrans[1] && hready;
  assign first_part = htrans[1] && hunalign && (haddr[1:0] != ALIGN_OFS);
  assign rem        = {2'h0, haddr[1:0]} + (4'h1 << hsize) - WORD_BYTES;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_FIRST_PART: assert property (first_part |-> htrans == TRANS_NONSEQ && hbstrb == (STRB_ALL << haddr[1:0]))
    else $error("first misaligned portion malformed");
  AST_SECOND_ADDR: assert property (take && first_part |=> htrans == TRANS_NONSEQ
    && haddr == (($past(haddr) & 32'hffff_fffc) + WORD_STEP) && hwrite == $past(hwrite))
    else $error("second misaligned portion address wrong");
  AST_SECOND_ATTR: assert property (take && first_part |=> hbstrb == 4'((4'h1 << $past(rem)) - 4'h1)
    && hsize == 2'($past(rem) - 4'h1) && hunalign == ($past(rem) == REM_THREE))
    else $error("second misaligned portion attributes wrong");
  AST_SEQ_INCR: assert property (htrans == TRANS_SEQ |-> hburst == BURST_INCR)
    else $error("sequential beat without incrementing burst");
  AST_BURST_ATTR: assert property (htrans[1] && hburst == BURST_INCR |-> hsize == SIZE_WORD
    && hbstrb == STRB_ALL && !hunalign && haddr[1:0] == ALIGN_OFS)
    else $error("burst beat attributes wrong");
  AST_SEQ_STEP: assert property (take ##1 htrans == TRANS_SEQ |-> haddr == $past(haddr) + WORD_STEP)
    else $error("burst address did not step by one word");
  AST_WRITE_HOLD: assert property (htrans[1] && hwrite && !hready && hresp == RESP_OKAY
    |=> htrans == $past(htrans) && haddr == $past(haddr) && hwrite)
    else $error("pending write changed before taken");
  AST_WAIT_HOLD: assert property (htrans[1] && !hready && hresp == RESP_OKAY |=> htrans[1])
    else $error("request dropped during wait state");
  AST_WDATA_HOLD: assert property (take && hwrite ##1 !hready |=> hwdata == $past(hwdata))
    else $error("write data moved during data phase");
  AST_ERR_TWO: assert property (!hready && hresp == RESP_ERROR |=> hready && hresp == RESP_ERROR)
    else $error("error response not two cycles");
  AST_ERR_DROP: assert property (hready && hresp == RESP_ERROR |-> htrans == TRANS_IDLE)
    else $error("pending request kept in second error cycle");
endmodule
`default_nettype wire

/* testbench/ahb_master_misalign_burst_retract_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ahb_master_misalign_burst_retract_tb;
  import amr_pkg::*;
  logic        clock_i, rst_i, req_valid, req_ready, req_write, req_burst, req_retract;
  logic        wr_valid, wr_ready, resp_valid, resp_write, resp_error, error_in, take_valid, take_write, wr;
  logic [1:0]  req_size, wait_in, sz;
  logic [7:0]  req_beats;
  logic [31:0] req_addr, wr_data, rd_data, take_addr, bad_addr, a;
  logic [31:0] mem [64];
  logic [33:0] expq [$];
  logic [33:0] e;
  int          fails, checked, bad_takes, kind;
  int          cycles = 0;

  amr_bus_if amr_bus_if_inst ();
  amr_master amr_master_inst (.clock_i(clock_i), .rst_i(rst_i), .bus(amr_bus_if_inst.master),
    .req_valid_i(req_valid), .req_ready_o(req_ready), .req_addr_i(req_addr), .req_write_i(req_write),
    .req_size_i(req_size), .req_burst_i(req_burst), .req_beats_i(req_beats), .req_retract_i(req_retract),
    .wr_valid_i(wr_valid), .wr_ready_o(wr_ready), .wr_data_i(wr_data), .resp_valid_o(resp_valid),
    .resp_write_o(resp_write), .resp_error_o(resp_error), .rd_data_o(rd_data));
  amr_slave amr_slave_inst (.clock_i(clock_i), .rst_i(rst_i), .bus(amr_bus_if_inst.slave),
    .wait_cycles_i(wait_in), .error_i(error_in), .take_valid_o(take_valid), .take_write_o(take_write),
    .take_addr_o(take_addr));
  amr_bus_properties amr_bus_properties_inst (.clock_i(clock_i), .rst_i(rst_i),
    .haddr(amr_bus_if_inst.haddr), .htrans(amr_bus_if_inst.htrans), .hburst(amr_bus_if_inst.hburst),
    .hsize(amr_bus_if_inst.hsize), .hbstrb(amr_bus_if_inst.hbstrb), .hwrite(amr_bus_if_inst.hwrite),
    .hunalign(amr_bus_if_inst.hunalign), .hwdata(amr_bus_if_inst.hwdata), .hready(amr_bus_if_inst.hready),
    .hresp(amr_bus_if_inst.hresp));

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Checks made %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // The bus hands each write word over unshifted, so only the strobed lanes land in memory.
  function automatic logic [3:0] lanes(input logic [31:0] ad, input logic [1:0] s, input logic bu, input int k);
    int rem;
    rem = int'(ad[1:0]) + (1 << s) - 4;
    if (bu) return STRB_ALL;
    if (k == 1) return 4'((1 << rem) - 1);
    return 4'(((1 << (1 << s)) - 1) << ad[1:0]);
  endfunction

  task automatic op(input logic [31:0] ad, input logic w, input logic [1:0] s, input logic bu,
                    input logic [7:0] nb, input logic retr, input logic err, input logic ghost);
    int n;
    int idx;
    logic [31:0] d;
    logic [3:0]  ln;
    idx = int'(ad[7:2]);
    n = bu ? ((nb == 8'h0) ? 1 : int'(nb)) : ((int'(ad[1:0]) + (1 << s) > 4 && !err) ? 2 : 1);
    if (w) begin
      req_valid <= 1'b0;
      for (int k = 0; k < n; k++) begin
        d = $urandom();
        wr_valid <= 1'b1;
        wr_data <= d;
        do @(negedge clock_i); while (wr_ready !== 1'b1);
        @(posedge clock_i);
        ln = lanes(ad, s, bu, k);
        for (int b = 0; b < 4; b++) if (ln[b]) mem[(idx + k) % 64][8*b +: 8] = d[8*b +: 8];
      end
      wr_valid <= 1'b0;
      if (n == 16 && ad == 32'h0) begin
        @(negedge clock_i);
        chk(wr_ready, 32'h0);
        @(posedge clock_i);
      end
    end
    for (int k = 0; k < n && !ghost; k++) expq.push_back({w, err, w ? 32'h0 : mem[(idx + k) % 64]});
    req_valid <= 1'b1;
    req_addr <= ad;
    req_write <= w;
    req_size <= s;
    req_burst <= bu;
    req_beats <= nb;
    req_retract <= retr;
    do @(negedge clock_i); while (req_ready !== 1'b1);
    @(posedge clock_i);
  endtask

  task automatic drain();
    req_valid <= 1'b0;
    while (expq.size() != 0) @(posedge clock_i);
    @(posedge clock_i);
  endtask

  always @(negedge clock_i) begin
    if (!rst_i && resp_valid === 1'b1) begin
      if (expq.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        e = expq.pop_front();
        chk(resp_write, e[33]);
        chk(resp_error, e[32]);
        if (e[33:32] === 2'b00) chk(rd_data, e[31:0]);
      end
    end
    if (take_valid === 1'b1 && take_addr === bad_addr) bad_takes++;
  end

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    rst_i = 1'b1;
    {req_valid, req_write, req_burst, req_retract, wr_valid, error_in} = 6'h0;
    {req_size, wait_in, req_beats, req_addr, wr_data} = 76'h0;
    {fails, checked, bad_takes} = 96'h0;
    bad_addr = 32'hffff_ffff;
    kind = $urandom(32'hd5130652);
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    for (int j = 0; j < 4; j++) begin
      wait_in <= 2'($urandom_range(0, 3));
      op(32'(j * 64), 1'b1, SIZE_WORD, 1'b1, 8'h10, 1'b0, 1'b0, 1'b0);
    end
    for (int i = 0; i < 60; i++) begin
      wait_in <= 2'($urandom_range(0, 3));
      kind = $urandom_range(0, 3);
      wr = 1'($urandom());
      a = {24'h0, 6'($urandom()), 2'h0};
      sz = 2'($urandom_range(1, 2));
      case (kind)
        0: op(a, 1'b0, SIZE_WORD, 1'b1, 8'($urandom_range(0, 8)), 1'b0, 1'b0, 1'b0);
        1: op(a | 32'($urandom_range(0, 3)), 1'b1, SIZE_WORD, 1'b1, 8'($urandom_range(1, 8)), 1'b0, 1'b0, 1'b0);
        2: op(a | ((sz == SIZE_HALF) ? 32'h3 : 32'($urandom_range(1, 3))), wr, sz, 1'b0, 8'h0, 1'b0, 1'b0, 1'b0);
        default: op(a, wr, 2'($urandom_range(0, 2)), 1'b0, 8'h0, 1'b0, 1'b0, 1'b0);
      endcase
    end
    // A four-beat read burst loses its later beats to a retracting single read.
    drain();
    wait_in <= WAIT_ONE + WAIT_ONE;
    bad_addr = 32'h14;
    expq.push_back({2'b00, mem[4]});
    op(32'h10, 1'b0, SIZE_WORD, 1'b1, 8'h04, 1'b0, 1'b0, 1'b1);
    op(32'h80, 1'b0, SIZE_WORD, 1'b0, 8'h0, 1'b1, 1'b0, 1'b0);
    drain();
    chk(bad_takes, 32'h0);
    chk(take_write, 32'h0);
    error_in <= 1'b1;
    wait_in <= WAIT_ZERO;
    op(32'h21, 1'b0, SIZE_WORD, 1'b0, 8'h0, 1'b0, 1'b1, 1'b0);
    drain();
    error_in <= 1'b0;
    op(32'h30, 1'b0, SIZE_WORD, 1'b0, 8'h0, 1'b0, 1'b0, 1'b0);
    drain();
    chk(wr_ready, 32'h1);
    summarize();
  end
endmodule
`default_nettype wire
